// *** rtl/pgsm_pkg.sv ***
// package: register map, field layout, serial framing and timing constants
package pgsm_pkg;

	// avalon register word indices (byte address = index * 4)
	localparam logic [3:0] PGSM_IDX_GAIN = 4'h0;
	localparam logic [3:0] PGSM_IDX_STATUS = 4'h1;
	localparam logic [3:0] PGSM_IDX_MASK = 4'h2;
	localparam logic [3:0] PGSM_IDX_SUPPLY = 4'h3;
	localparam logic [3:0] PGSM_IDX_SPI_ADDR = 4'h4;

	// gain register field positions
	localparam int PGSM_CUR_GAIN_LSB = 0;
	localparam int PGSM_NOLOAD_LSB = 2;
	localparam int PGSM_ABS_SUM_BIT = 4;
	localparam int PGSM_VOLT_GAIN_LSB = 5;
	localparam int PGSM_GAIN_SPARE_BIT = 7;
	localparam logic [7:0] PGSM_GAIN_RESET = 8'h00;

	// gain codes and decoded multipliers
	localparam logic [1:0] PGSM_GCODE_X1 = 2'h0;
	localparam logic [1:0] PGSM_GCODE_X2 = 2'h1;
	localparam logic [1:0] PGSM_GCODE_X4 = 2'h2;
	localparam logic [2:0] PGSM_GAIN_X1 = 3'h1;
	localparam logic [2:0] PGSM_GAIN_X2 = 3'h2;
	localparam logic [2:0] PGSM_GAIN_X4 = 3'h4;

	// status bit positions
	localparam int PGSM_ST_SUPPLY_LOW = 0;
	localparam int PGSM_ST_SPI_WRITE = 1;
	localparam int PGSM_ST_SUPPLY_OK = 2;
	localparam int PGSM_ST_WIDTH = 3;
	localparam logic [2:0] PGSM_MASK_ALWAYS_OFF = 3'h1;
	localparam logic [2:0] PGSM_ST_RESET = 3'h0;
	localparam logic [2:0] PGSM_MASK_RESET = 3'h0;

	// serial framing: command byte bit 7 = write, low bits = register address
	localparam int PGSM_SPI_WRITE_BIT = 7;
	localparam logic [6:0] PGSM_SPI_GAIN_ADDR_RESET = 7'h18;
	localparam logic [3:0] PGSM_SPI_LAST_BIT = 4'h7;

	// supply filter: level must persist this long before the state flips
	localparam int PGSM_FILTER_NS = 1000;
	localparam int PGSM_CLK_NS = 4;
	localparam int PGSM_FILTER_CYC = PGSM_FILTER_NS / PGSM_CLK_NS;

	// serial engine phase
	typedef enum logic [1:0] {PGSM_PH_CMD, PGSM_PH_WDATA, PGSM_PH_RDATA, PGSM_PH_DONE} pgsm_ph_e;

	// synchronised pins
	typedef struct packed {
		logic sclk;
		logic cs_b;
		logic din;
		logic supply_low;
	} pgsm_pins_s;

	// whole state of the block
	typedef struct packed {
		logic [7:0] gain;
		logic [2:0] status;
		logic [2:0] mask;
		logic [6:0] spi_addr;
		logic supply_low;
		logic [8:0] filt_cnt;
		logic sclk_d;
		pgsm_ph_e ph;
		logic [3:0] bit_cnt;
		logic [7:0] shift;
		logic [7:0] cmd;
		logic dout;
		logic dout_en;
		logic rd_valid;
		logic [31:0] rd_data;
	} pgsm_state_s;

endpackage

// *** rtl/pgsm_top.sv ***
// gain select register, supply monitor, serial port and avalon slave
//
// Function
// - capture serial data on falling clock edge
// - launch serial data on rising clock edge
// - data output released unless actively driving
// - halt accumulation while supply below threshold
// - supply detection filtered with hysteresis
// - supply-low sets status flag
// - supply-low flag never raises interrupt
// - one gain of 1,2,4 per channel
// - current gain from bits 0 and 1
// - voltage gain from bits 5 and 6
// - register holds no-load and abs-sum settings
// - reset holds all logic including serial
// - interrupt output active-low open-drain
`timescale 1ns/1ps
module pgsm_top
	import pgsm_pkg::*;
#(
	parameter int FILTER_CYC = PGSM_FILTER_CYC
) (
	// clock, enable, reset
	input wire logic clk,
	input wire logic clk_en,
	input wire logic rst_b,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// serial port pins
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic din,
	output logic dout_o,
	output logic dout_oe,
	// analog supply comparator (high when supply below threshold)
	input wire logic analog_supply_low,
	// interrupt pin, open drain
	output logic irq_b_o,
	output logic irq_b_oe,
	// controls to the analog and accumulation sections
	output logic [2:0] current_channel_amplifier,
	output logic [2:0] voltage_channel_amplifier,
	output logic [1:0] noload_sel,
	output logic abs_sum_en,
	output logic accum_enable
);

	logic [1:0] rst_sync_r;
	logic rst_n_int;
	pgsm_pins_s pins_m_r;
	pgsm_pins_s pins_r;
	pgsm_state_s st_r;
	pgsm_state_s st_nxt;

	// map a gain code to a multiplier; reserved code acts as one
	function automatic logic [2:0] gain_decode(input logic [1:0] code);
		logic [2:0] g;
		g = PGSM_GAIN_X1;
		unique case (code)
			PGSM_GCODE_X2: g = PGSM_GAIN_X2;
			PGSM_GCODE_X4: g = PGSM_GAIN_X4;
			default: g = PGSM_GAIN_X1;
		endcase
		return g;
	endfunction

	// merge one byte-lane write into a register word
	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] wd,
		input logic be);
		return be ? wd : old;
	endfunction

	// reset release through two flops
	// whole block reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync_r[1];

	// two-flop synchronisers for every pin input
	always_ff @(posedge clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			pins_m_r <= '{sclk: 1'b0, cs_b: 1'b1, din: 1'b0, supply_low: 1'b0};
			pins_r <= '{sclk: 1'b0, cs_b: 1'b1, din: 1'b0, supply_low: 1'b0};
		end else if (clk_en) begin
			pins_m_r <= '{sclk: sclk, cs_b: cs_b, din: din, supply_low: analog_supply_low};
			pins_r <= pins_m_r;
		end
	end

	// next-state logic for the whole block
	always_comb begin
		logic sclk_rise;
		logic sclk_fall;
		logic [7:0] byte_in;
		logic [31:0] rd_word;
		logic [2:0] st_set;
		logic [2:0] w1c;
		logic wr_gain_spi;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		byte_in = 8'h00;
		rd_word = 32'h0;
		st_set = 3'h0;
		w1c = 3'h0;
		wr_gain_spi = 1'b0;
		st_nxt = st_r;
		st_nxt.sclk_d = pins_r.sclk;
		st_nxt.rd_valid = 1'b0;
		sclk_rise = pins_r.sclk & ~st_r.sclk_d;
		sclk_fall = ~pins_r.sclk & st_r.sclk_d;

		// supply monitor: level must hold FILTER_CYC cycles before the state flips
		// filtered hysteretic detect
		if (pins_r.supply_low != st_r.supply_low) begin
			if (st_r.filt_cnt >= 9'(FILTER_CYC - 1)) begin
				st_nxt.supply_low = pins_r.supply_low;
				st_nxt.filt_cnt = 9'h0;
				st_set[PGSM_ST_SUPPLY_LOW] = pins_r.supply_low;
				st_set[PGSM_ST_SUPPLY_OK] = ~pins_r.supply_low;
			end else begin
				st_nxt.filt_cnt = st_r.filt_cnt + 9'h1;
			end
		end else begin
			st_nxt.filt_cnt = 9'h0;
		end

		// serial port: framing only while selected
		// select gates the frame
		if (pins_r.cs_b) begin
			st_nxt.ph = PGSM_PH_CMD;
			st_nxt.bit_cnt = 4'h0;
			st_nxt.dout_en = 1'b0;
		end else begin
			if (sclk_fall && st_r.ph != PGSM_PH_DONE) begin
				byte_in = {st_r.shift[6:0], pins_r.din};
				st_nxt.shift = byte_in;
				st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
				if (st_r.bit_cnt == PGSM_SPI_LAST_BIT) begin
					st_nxt.bit_cnt = 4'h0;
					unique case (st_r.ph)
						PGSM_PH_CMD: begin
							st_nxt.cmd = byte_in;
							if (byte_in[PGSM_SPI_WRITE_BIT]) begin
								st_nxt.ph = PGSM_PH_WDATA;
							end else begin
								st_nxt.ph = PGSM_PH_RDATA;
								st_nxt.shift = (byte_in[6:0] == st_r.spi_addr) ?
									st_r.gain : 8'h00;
							end
						end
						PGSM_PH_WDATA: begin
							st_nxt.ph = PGSM_PH_DONE;
							wr_gain_spi = (st_r.cmd[6:0] == st_r.spi_addr);
						end
						default: st_nxt.ph = PGSM_PH_DONE;
					endcase
				end
			end
			if (sclk_rise && st_r.ph == PGSM_PH_RDATA) begin
				// the shifter moves on every falling edge, so its msb is always the next bit
				st_nxt.dout = st_r.shift[PGSM_SPI_LAST_BIT[2:0]];
				st_nxt.dout_en = 1'b1;
			end else if (st_r.ph != PGSM_PH_RDATA) begin
				st_nxt.dout_en = 1'b0;
			end
		end
		if (wr_gain_spi) begin
			// full byte incl. no-load and abs-sum
			st_nxt.gain = byte_in;
			st_set[PGSM_ST_SPI_WRITE] = 1'b1;
		end

		// avalon slave: answers the cycle after the request, waitrequest low then
		if ((avs_write || avs_read) && !st_r.rd_valid) begin
			st_nxt.rd_valid = 1'b1;
			unique case (avs_address)
				PGSM_IDX_GAIN: rd_word = {24'h0, st_r.gain};
				PGSM_IDX_STATUS: rd_word = {29'h0, st_r.status};
				PGSM_IDX_MASK: rd_word = {29'h0, st_r.mask};
				PGSM_IDX_SUPPLY: rd_word = {31'h0, st_r.supply_low};
				PGSM_IDX_SPI_ADDR: rd_word = {25'h0, st_r.spi_addr};
				default: rd_word = 32'h0;
			endcase
			st_nxt.rd_data = avs_read ? rd_word : 32'h0;
		end
		// writes commit at the edge where waitrequest is seen low, not earlier
		if (avs_write && st_r.rd_valid) begin
			unique case (avs_address)
					PGSM_IDX_GAIN: st_nxt.gain = lane_merge(st_r.gain, avs_writedata[7:0],
						avs_byteenable[0]);
					PGSM_IDX_STATUS: w1c = avs_byteenable[0] ?
						avs_writedata[PGSM_ST_WIDTH-1:0] : 3'h0;
					// supply flag bit cannot be unmasked
					PGSM_IDX_MASK: if (avs_byteenable[0]) begin
						st_nxt.mask = avs_writedata[PGSM_ST_WIDTH-1:0] & ~PGSM_MASK_ALWAYS_OFF;
					end
					PGSM_IDX_SPI_ADDR: if (avs_byteenable[0]) begin
						st_nxt.spi_addr = avs_writedata[6:0];
					end
					default: ;
			endcase
		end

		// sticky status: set wins over a write-one clear
		st_nxt.status = (st_r.status & ~w1c) | st_set;
	end

	// single state register
	always_ff @(posedge clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			st_r <= '{gain: PGSM_GAIN_RESET, status: PGSM_ST_RESET, mask: PGSM_MASK_RESET,
				spi_addr: PGSM_SPI_GAIN_ADDR_RESET, ph: PGSM_PH_CMD, default: '0};
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// avalon handshake and read data
	assign avs_waitrequest = (avs_read || avs_write) && !st_r.rd_valid;
	assign avs_readdata = st_r.rd_data;

	// serial output pin
	assign dout_o = st_r.dout;
	assign dout_oe = st_r.dout_en & ~pins_r.cs_b;

	// interrupt: open drain, pulled low while an unmasked flag is set
	// supply flag masked off
	assign irq_b_o = 1'b0;
	assign irq_b_oe = |(st_r.status & st_r.mask & ~PGSM_MASK_ALWAYS_OFF);

	// amplifier and accumulation controls
	// one gain per channel
	assign current_channel_amplifier = gain_decode(st_r.gain[PGSM_CUR_GAIN_LSB +: 2]);
	assign voltage_channel_amplifier = gain_decode(st_r.gain[PGSM_VOLT_GAIN_LSB +: 2]);
	assign noload_sel = st_r.gain[PGSM_NOLOAD_LSB +: 2];
	assign abs_sum_en = st_r.gain[PGSM_ABS_SUM_BIT];
	assign accum_enable = ~st_r.supply_low;

endmodule

// *** verification/pgsm_asserts.sv ***
// checker: port-level properties of the gain and supply block
`timescale 1ns/1ps
module pgsm_asserts
	import pgsm_pkg::*;
#(
	parameter int FILTER_CYC = 4
) (
	// clock, reset, bus
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// serial, supply, irq
	input wire logic sclk,
	input wire logic cs_b,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic analog_supply_low,
	input wire logic accum_enable,
	input wire logic irq_b_o,
	// decoded controls
	input wire logic [2:0] current_channel_amplifier,
	input wire logic [2:0] voltage_channel_amplifier,
	input wire logic [1:0] noload_sel,
	input wire logic abs_sum_en
);
	logic [9:0] lo_cnt_r;
	logic [1:0] gw_r;
	logic [7:0] gd_r;
	logic gw_now;
	assign gw_now = avs_write && !avs_waitrequest && avs_address == PGSM_IDX_GAIN;
	// low-supply run length and the last gain write, flagged two cycles on
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lo_cnt_r <= 10'h000;
			gw_r <= 2'h0;
			gd_r <= 8'h00;
		end else begin
			lo_cnt_r <= !analog_supply_low ? 10'h000 : lo_cnt_r + {9'h000, lo_cnt_r != 10'h3ff};
			gw_r <= {gw_r[0], gw_now};
			gd_r <= gw_now ? avs_writedata[7:0] : gd_r;
		end
	end
	function automatic logic [2:0] dec(input logic [1:0] c);
		return c == PGSM_GCODE_X2 ? PGSM_GAIN_X2 : c == PGSM_GCODE_X4 ? PGSM_GAIN_X4 : PGSM_GAIN_X1;
	endfunction
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	irq_low_a: assert property (irq_b_o == 1'h0)
		else $error("irq pin not low");
	dout_off_a: assert property (cs_b [*4] |-> !dout_oe)
		else $error("dout driven while deselected");
	dout_edge_a: assert property (($changed(dout_o) && dout_oe && $past(dout_oe)) |-> sclk)
		else $error("dout moved with clock low");
	accum_stop_a: assert property ((lo_cnt_r > FILTER_CYC + 6) |-> !accum_enable)
		else $error("accumulation not halted");
	filt_fall_a: assert property ($fell(accum_enable) |-> lo_cnt_r >= FILTER_CYC)
		else $error("supply glitch not filtered");
	wait_state_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	cur_gain_a: assert property (gw_r[1] |-> current_channel_amplifier == dec(gd_r[1:0]))
		else $error("current gain wrong");
	volt_gain_a: assert property (gw_r[1] |-> voltage_channel_amplifier == dec(gd_r[6:5]))
		else $error("voltage gain wrong");
	noload_fld_a: assert property (gw_r[1] |-> {abs_sum_en, noload_sel} == gd_r[4:2])
		else $error("no-load fields wrong");
	cover property (!accum_enable);
	cover property (dout_oe);
	cover property (gw_r[1]);
endmodule
bind pgsm_top pgsm_asserts #(.FILTER_CYC(FILTER_CYC)) chk_u (.clk(clk), .rst_b(rst_b),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .sclk(sclk),
	.cs_b(cs_b), .dout_o(dout_o), .dout_oe(dout_oe), .analog_supply_low(analog_supply_low),
	.accum_enable(accum_enable), .irq_b_o(irq_b_o),
	.current_channel_amplifier(current_channel_amplifier),
	.voltage_channel_amplifier(voltage_channel_amplifier), .noload_sel(noload_sel),
	.abs_sum_en(abs_sum_en));

// *** verification/pgsm_host_model.sv ***
// host model: serial master sending one 16-bit frame per go pulse
`timescale 1ns/1ps
module pgsm_host_model (
	// frame request and result
	input wire logic go,
	input wire logic [15:0] frame,
	output logic [7:0] rdata,
	output logic done,
	// serial pins
	output logic sclk,
	output logic cs_b,
	output logic din,
	input wire logic dout
);
	initial begin
		sclk = 1'h0;
		cs_b = 1'h1;
		din = 1'h0;
		done = 1'h0;
		rdata = 8'h00;
	end
	always @(posedge go) begin
		done = 1'h0;
		#1.3 cs_b = 1'h0;
		for (int i = 15; i >= 0; i--) begin
			// data moves mid low phase so it stands steady around the falling edge
			#12 din = frame[i];
			#12 sclk = 1'h1;
			#24 sclk = 1'h0;
			if (i < 8) rdata[i] = dout;
		end
		// clock parks low, data line flips once released
		#24 cs_b = 1'h1;
		din = ~din;
		done = 1'h1;
	end
endmodule

// *** verification/pgsm_top_bench.sv ***
// bench: registers, serial frames and supply monitor of the gain block
`timescale 1ns/1ps
module pgsm_top_bench
	import pgsm_pkg::*;
;
	localparam int FC = 4;
	logic clk = 1'h0, rst_b = 1'h0, rd = 1'h0, wr = 1'h0, sup = 1'h0, go = 1'h0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [15:0] frame = 16'h0;
	logic [7:0] lf = 8'h52;
	logic [31:0] rdata;
	logic [7:0] srd;
	logic [2:0] cur_g, volt_g;
	logic [1:0] nl;
	logic wreq, sclk, cs_b, din, dout_o, dout_oe, irq_o, irq_oe, abs_en, acc, done;
	wire dout_w = dout_oe ? dout_o : 1'bz;
	logic [31:0] aq[$];
	logic [8:0] sq[$];
	int mismatches = 0, cmp_count = 0;
	pgsm_top #(.FILTER_CYC(FC)) dut_u (.clk(clk), .clk_en(1'h1), .rst_b(rst_b),
		.avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
		.avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq),
		.sclk(sclk), .cs_b(cs_b), .din(din), .dout_o(dout_o), .dout_oe(dout_oe),
		.analog_supply_low(sup), .irq_b_o(irq_o), .irq_b_oe(irq_oe),
		.current_channel_amplifier(cur_g), .voltage_channel_amplifier(volt_g),
		.noload_sel(nl), .abs_sum_en(abs_en), .accum_enable(acc));
	pgsm_host_model host_u (.go(go), .frame(frame), .rdata(srd), .done(done),
		.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout_w));
	initial forever #2 clk = ~clk;
	function automatic logic [7:0] nxt(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	function automatic logic [2:0] dec(input logic [1:0] c);
		return c == 2'h1 ? 3'h2 : c == 2'h2 ? 3'h4 : 3'h1;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		do @(posedge clk); while (wreq !== 1'h0);
		rd <= 1'h0;
		wr <= 1'h0;
		@(posedge clk);
	endtask
	task automatic rdx(input logic [3:0] a, input logic [31:0] e);
		aq.push_back(e);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic ser(input logic [15:0] f, input logic [8:0] e);
		sq.push_back(e);
		frame <= f;
		go <= 1'h1;
		@(posedge done);
		go <= 1'h0;
		repeat (4) @(posedge clk);
	endtask
	task automatic stop_test;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// result watchers take the oldest note
	always @(posedge clk) if (rd && wreq === 1'h0) chk(rdata, aq.pop_front());
	always @(posedge done) begin
		if (sq[0][8]) chk({24'h0, srd}, {24'h0, sq[0][7:0]});
		void'(sq.pop_front());
	end
	initial begin
		#40000;
		mismatches++;
		stop_test;
	end
	initial begin
		logic [7:0] g;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		repeat (3) @(posedge clk);
		rdx(PGSM_IDX_GAIN, 32'h0);
		rdx(PGSM_IDX_SPI_ADDR, 32'h18);
		rdx(4'h9, 32'h0);
		$display("reset test done");
		for (int c = 0; c < 4; c++) begin
			lf = nxt(lf);
			g = {lf[7], c[1:0], lf[4:2], c[1:0]};
			bus(1'h1, PGSM_IDX_GAIN, {24'h0, g});
			@(posedge clk);
			chk(cur_g, dec(c[1:0]));
			chk(volt_g, dec(c[1:0]));
			chk({abs_en, nl}, g[4:2]);
			rdx(PGSM_IDX_GAIN, {24'h0, g});
		end
		$display("gain test done");
		lf = nxt(lf);
		g = lf;
		ser({1'h1, PGSM_SPI_GAIN_ADDR_RESET, g}, 9'h0);
		rdx(PGSM_IDX_GAIN, {24'h0, g});
		rdx(PGSM_IDX_STATUS, 32'h2);
		ser({1'h0, PGSM_SPI_GAIN_ADDR_RESET, 8'h0}, {1'h1, g});
		ser({1'h1, 7'h05, ~g}, 9'h0);
		rdx(PGSM_IDX_GAIN, {24'h0, g});
		bus(1'h1, PGSM_IDX_STATUS, 32'h2);
		rdx(PGSM_IDX_STATUS, 32'h0);
		$display("serial test done");
		// short glitch first, then a real drop and recovery
		sup <= 1'h1;
		repeat (FC - 2) @(posedge clk);
		sup <= 1'h0;
		repeat (20) @(posedge clk);
		chk(acc, 1'h1);
		bus(1'h1, PGSM_IDX_MASK, 32'h7);
		sup <= 1'h1;
		repeat (20) @(posedge clk);
		chk(acc, 1'h0);
		rdx(PGSM_IDX_STATUS, 32'h1);
		rdx(PGSM_IDX_MASK, 32'h6); // bit0 reads back as masked
		rdx(PGSM_IDX_SUPPLY, 32'h1);
		chk(irq_oe, 1'h0);
		sup <= 1'h0;
		repeat (20) @(posedge clk);
		chk(acc, 1'h1);
		chk({irq_oe, irq_o}, 2'h2);
		bus(1'h1, PGSM_IDX_STATUS, 32'h7);
		@(posedge clk);
		chk(irq_oe, 1'h0);
		$display("supply test done");
		stop_test;
	end
endmodule
